// file: shared/rib_defines.svh
// constants for the rom and external i/o bus interface
`ifndef RIB_DEFINES_SVH
`define RIB_DEFINES_SVH
`define RIB_SPACE_TOP 6'h3F
`define RIB_ROM_BASE 3'h7
`define RIB_IO1_BASE 3'h6
`define RIB_IO2_BASE 3'h5
`define RIB_SZ_1 6'h01
`define RIB_SZ_2 6'h02
`define RIB_SZ_3 6'h03
`define RIB_SZ_4 6'h04
`define RIB_SZ_8 6'h08
`define RIB_SZ_16 6'h10
`define RIB_SZ_32 6'h20
`define RIB_ALLOC_RST 2'h3
`define RIB_ALLOC_RFU 2'h1
`define RIB_ACC_LEN 4'h3
`endif

// file: shared/rib_pkg.sv
// types for the rom and external i/o bus interface
package rib_pkg;
  typedef enum logic [1:0] {
    RIB_SP_ROM = 2'h0,
    RIB_SP_IO = 2'h1,
    RIB_SP_MEM = 2'h2
  } rib_space_t;
  typedef enum logic [2:0] {
    RIB_ROM_NORMAL = 3'h1,
    RIB_ROM_PAGE = 3'h2,
    RIB_ROM_FLASH = 3'h4
  } rib_rom_mode_t;
  typedef enum logic [3:0] {
    RIB_ST_IDLE = 4'h1,
    RIB_ST_STROBE = 4'h2,
    RIB_ST_HOLD = 4'h4,
    RIB_ST_DONE = 4'h8
  } rib_state_t;
endpackage : rib_pkg

// file: core/rib_addr_map.sv
// maps physical address bits onto the external address pins for every access
module rib_addr_map
  import rib_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // address and mode
  input wire logic [25:0] phys_addr,
  input wire logic wide_bus_select,
  input wire logic load,
  // pins
  output logic [24:1] addr_pin_q
);
  logic [24:1] addr_d;

  always_comb begin
    if (wide_bus_select) begin
      addr_d = {phys_addr[24:2], phys_addr[25]};
    end else begin
      addr_d = {1'b0, phys_addr[23:1]};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_pin_q <= '0;
    end else if (load) begin
      addr_pin_q <= addr_d;
    end
  end

  AST_WIDE_A1: assert property (@(posedge mclk) disable iff (sys_rst)
    load && wide_bus_select |=> addr_pin_q[1] == $past(phys_addr[25]))
    else $error("pin one must carry address bit 25");
  AST_NARROW_MAP: assert property (@(posedge mclk) disable iff (sys_rst)
    load && !wide_bus_select |=> addr_pin_q[23:1] == $past(phys_addr[23:1]))
    else $error("narrow bus pins must carry address 23 to 1");
endmodule : rib_addr_map

// file: core/rib_size_check.sv
// decides whether a transfer size is allowed for a space
`include "rib_defines.svh"
module rib_size_check
  import rib_pkg::*;
(
  // request
  input wire logic [1:0] space,
  input wire logic [5:0] size,
  input wire logic is_write,
  input wire logic is_flash_write,
  // verdict
  output logic size_ok
);
  function automatic logic size_known(input logic [5:0] s);
    size_known = (s == `RIB_SZ_1) || (s == `RIB_SZ_2) || (s == `RIB_SZ_3) ||
                 (s == `RIB_SZ_4) || (s == `RIB_SZ_8) ||
                 (s == `RIB_SZ_16) || (s == `RIB_SZ_32);
  endfunction : size_known

  always_comb begin
    size_ok = size_known(size);
    if (space == RIB_SP_IO && size == `RIB_SZ_3) begin
      size_ok = 1'b0;
    end
    if (is_write && space == RIB_SP_ROM && !is_flash_write) begin
      size_ok = 1'b1;
    end
  end
endmodule : rib_size_check

// file: core/rib_bus_if.sv
// rom, flash and external i/o bus interface with buffer direction control
// Notes on behaviour
// - narrow bus: address pin n carries physical bit n, 1 to 23
// - wide bus: pins 2..24 carry bits 2..24, pin 1 carries bit 25
// - rom, flash reads, dram, pci accept sizes 1,2,3,4,8,16,32
// - external i/o takes 1,2,4,8,16,32 bytes; 3 bytes refused
// - write-mode and page-read bits pick normal, page or flash mode
// - normal rom mode after reset
// - normal rom mode never asserts write strobe on rom writes
// - rom speed programmable only in normal or page mode
// - i/o uses 32-bit bus when width bit set on wide bus
// - bank allocation takes effect only on the wide bus
// - shared pin gives direction when select bit set, else pin six
// - buffer use selected separately for i/o space one and two
// - direction floats in hold, high on buffered i/o reads only
// - direction rises with read strobe fall, drops one clock later
// - bank field and i/o width bit writable only on the wide bus
`include "rib_defines.svh"
module rib_bus_if
  import rib_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // configuration
  input wire logic wide_bus_select,
  input wire logic cfg_write,
  input wire logic rom_write_mode_bit,
  input wire logic page_read_mode_bit,
  input wire logic [1:0] bank_alloc_field,
  input wire logic io_bus_width_bit,
  input wire logic direction_pin_select,
  input wire logic buffer_use_space_one,
  input wire logic buffer_use_space_two,
  input wire logic [2:0] speed_in,
  input wire logic bus_hold,
  // access request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [25:0] req_addr,
  input wire logic [5:0] req_size,
  // general pin six from its own logic
  input wire logic general_pin_six_out,
  input wire logic general_pin_six_oe,
  // status
  output logic busy_q,
  output logic size_error_q,
  output logic [2:0] rom_mode_q,
  output logic [1:0] bank_alloc_q,
  output logic io_wide_q,
  output logic [2:0] rom_speed_q,
  // external pins
  output logic [24:1] addr_pin_q,
  output logic rd_n_q,
  output logic wr_n_q,
  output logic shared_pin_out_q,
  output logic shared_pin_oe_q
);
  rib_state_t state_q;
  logic [1:0] space;
  logic size_ok;
  logic wr_q;
  logic rom_flash;
  logic [3:0] cnt_q;
  logic dir_start;
  logic dir_q;
  logic buffered_q;
  logic take;

  // space select bits that name an external i/o space
  function automatic logic io_hit(input logic [2:0] sel);
    io_hit = (sel == `RIB_IO1_BASE) || (sel == `RIB_IO2_BASE);
  endfunction : io_hit

  // i/o space reached through the load buffer
  function automatic logic buf_hit(input logic [2:0] sel, input logic one,
                                   input logic two);
    buf_hit = (sel == `RIB_IO1_BASE && !one) ||
              (sel == `RIB_IO2_BASE && !two);
  endfunction : buf_hit

  always_comb begin
    space = RIB_SP_MEM;
    if (req_addr[25:23] == `RIB_ROM_BASE) begin
      space = RIB_SP_ROM;
    end
    if (io_hit(req_addr[25:23])) begin
      space = RIB_SP_IO;
    end
  end

  assign rom_flash = rom_mode_q == RIB_ROM_FLASH;
  assign take = req_valid && state_q == RIB_ST_IDLE;

  // rom mode and configuration bits
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rom_mode_q <= RIB_ROM_NORMAL;
    end else if (cfg_write) begin
      if (rom_write_mode_bit) begin
        rom_mode_q <= RIB_ROM_FLASH;
      end else if (page_read_mode_bit) begin
        rom_mode_q <= RIB_ROM_PAGE;
      end else begin
        rom_mode_q <= RIB_ROM_NORMAL;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_alloc_q <= `RIB_ALLOC_RST;
      io_wide_q <= 1'b0;
    end else if (cfg_write && wide_bus_select) begin
      if (bank_alloc_field != `RIB_ALLOC_RFU) begin
        bank_alloc_q <= bank_alloc_field;
      end
      io_wide_q <= io_bus_width_bit;
    end else if (!wide_bus_select) begin
      io_wide_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rom_speed_q <= '0;
    end else if (cfg_write && !rom_write_mode_bit && !rom_flash) begin
      rom_speed_q <= speed_in;
    end
  end

  rib_size_check u_size (
    .space(space),
    .size(req_size),
    .is_write(req_write),
    .is_flash_write(rom_flash),
    .size_ok(size_ok)
  );

  rib_addr_map u_map (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .phys_addr(req_addr),
    .wide_bus_select(wide_bus_select),
    .load(take),
    .addr_pin_q(addr_pin_q)
  );

  // access sequencer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= RIB_ST_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      buffered_q <= 1'b0;
      size_error_q <= 1'b0;
    end else begin
      case (state_q)
        RIB_ST_IDLE: begin
          if (req_valid) begin
            if (size_ok) begin
              state_q <= RIB_ST_STROBE;
              size_error_q <= 1'b0;
            end else begin
              size_error_q <= 1'b1;
            end
            cnt_q <= `RIB_ACC_LEN;
            wr_q <= req_write;
            buffered_q <= !req_write && buf_hit(req_addr[25:23],
              buffer_use_space_one, buffer_use_space_two);
          end
        end
        RIB_ST_STROBE: begin
          if (cnt_q == 4'h1) begin
            state_q <= RIB_ST_DONE;
          end
          cnt_q <= cnt_q - 4'h1;
        end
        RIB_ST_DONE: begin
          state_q <= RIB_ST_IDLE;
        end
        default: begin
          state_q <= RIB_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      busy_q <= take && size_ok || (state_q == RIB_ST_STROBE &&
                cnt_q != 4'h1);
      if (take && size_ok) begin
        rd_n_q <= req_write;
        wr_n_q <= !(req_write && (space != RIB_SP_ROM || rom_flash));
      end else if (state_q == RIB_ST_STROBE && cnt_q == 4'h1) begin
        rd_n_q <= 1'b1;
        wr_n_q <= 1'b1;
      end
    end
  end

  // direction pulse: high with read strobe fall, low one clock later
  assign dir_start = take && size_ok && !req_write &&
    buf_hit(req_addr[25:23], buffer_use_space_one, buffer_use_space_two);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_q <= 1'b0;
    end else begin
      dir_q <= dir_start;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_pin_out_q <= 1'b0;
      shared_pin_oe_q <= 1'b0;
    end else if (direction_pin_select) begin
      shared_pin_out_q <= dir_start;
      shared_pin_oe_q <= !bus_hold;
    end else begin
      shared_pin_out_q <= general_pin_six_out;
      shared_pin_oe_q <= general_pin_six_oe;
    end
  end

  AST_RESET_NORMAL: assert property (@(posedge mclk)
    $fell(sys_rst) |-> rom_mode_q == RIB_ROM_NORMAL)
    else $error("rom mode not normal after reset");
  AST_NO_ROM_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    take && req_write && space == RIB_SP_ROM && !rom_flash && size_ok
    |=> wr_n_q)
    else $error("write strobe asserted in normal rom mode");
  AST_IO_NO_3: assert property (@(posedge mclk) disable iff (sys_rst)
    take && space == RIB_SP_IO && req_size == `RIB_SZ_3 |=> size_error_q)
    else $error("three byte i/o transfer accepted");
  AST_DIR_PULSE: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(dir_q) |-> $fell(rd_n_q) ##1 !dir_q)
    else $error("direction pulse misplaced");
  AST_DIR_BUFFERED: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(dir_q) |-> buffered_q && !wr_q)
    else $error("direction high on non buffered access");
  AST_PIN_SEL: assert property (@(posedge mclk) disable iff (sys_rst)
    !direction_pin_select |=> shared_pin_out_q == $past(general_pin_six_out))
    else $error("shared pin not general pin six");
  AST_NARROW_IO: assert property (@(posedge mclk) disable iff (sys_rst)
    !wide_bus_select |=> !io_wide_q)
    else $error("i/o wide on narrow bus");
  AST_SPEED_LOCK: assert property (@(posedge mclk) disable iff (sys_rst)
    rom_flash && !cfg_write |=> $stable(rom_speed_q))
    else $error("rom speed changed in flash mode");
  // direction pin and read strobe checks
  AST_DIR_PIN: assert property (@(posedge mclk) disable iff (sys_rst)
    direction_pin_select |=> shared_pin_out_q == dir_q)
    else $error("shared pin does not follow direction");
  AST_DIR_OE_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    direction_pin_select && bus_hold |=> !shared_pin_oe_q)
    else $error("direction driven during bus hold");
  AST_DIR_OE_RUN: assert property (@(posedge mclk) disable iff (sys_rst)
    direction_pin_select && !bus_hold |=> shared_pin_oe_q)
    else $error("direction not driven outside bus hold");
  AST_DIR_WRITE_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
    take && req_write |=> !dir_q)
    else $error("direction high on a write");
  AST_STROBE_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(rd_n_q) |-> !rd_n_q [*3] ##1 rd_n_q)
    else $error("read strobe length wrong");
  // configuration and access checks
  AST_BANK_NARROW: assert property (@(posedge mclk) disable iff (sys_rst)
    !wide_bus_select |=> $stable(bank_alloc_q))
    else $error("bank field changed on narrow bus");
  AST_BANK_RFU: assert property (@(posedge mclk) disable iff (sys_rst)
    cfg_write && bank_alloc_field == `RIB_ALLOC_RFU |=> $stable(bank_alloc_q))
    else $error("reserved bank value taken");
  AST_MODE_FLASH: assert property (@(posedge mclk) disable iff (sys_rst)
    cfg_write && rom_write_mode_bit |=> rom_flash)
    else $error("write mode bit did not select flash");
  AST_MODE_PAGE: assert property (@(posedge mclk) disable iff (sys_rst)
    cfg_write && !rom_write_mode_bit && page_read_mode_bit
    |=> rom_mode_q == RIB_ROM_PAGE)
    else $error("page read bit did not select page mode");
  AST_SIZE_REFUSED: assert property (@(posedge mclk) disable iff (sys_rst)
    take && !size_ok |=> rd_n_q && wr_n_q && !busy_q)
    else $error("refused size started a strobe");
  AST_IO_WIDE_SET: assert property (@(posedge mclk) disable iff (sys_rst)
    cfg_write && wide_bus_select && io_bus_width_bit |=> io_wide_q)
    else $error("i/o width bit not taken on wide bus");
  AST_FLASH_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    take && size_ok && req_write && space == RIB_SP_ROM && rom_flash
    |=> !wr_n_q)
    else $error("flash write strobe missing");
  COV_SIZE_ERR: cover property (@(posedge mclk) $rose(size_error_q));
  COV_IO_READ: cover property (@(posedge mclk) $rose(dir_q));
  COV_FLASH: cover property (@(posedge mclk) rom_flash && !wr_n_q);
  COV_PAGE: cover property (@(posedge mclk) rom_mode_q == RIB_ROM_PAGE);
endmodule : rib_bus_if

// file: tb/rib_ext_dev.sv
// external rom, flash and i/o device model seen from its pins
module rib_ext_dev (
  // clock and strobes
  input wire logic mclk,
  input wire logic rd_n,
  input wire logic wr_n,
  // buffer direction pin
  input wire logic dir,
  input wire logic dir_oe,
  // observations
  output logic toward_cpu,
  output logic [7:0] wr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // only i/o sits behind the buffer; high passes data toward the core
  assign toward_cpu = dir_oe & dir & ~rd_n;
  initial wr_cnt = 8'h00;
  // count write strobes that reach the device
  always @(negedge wr_n) begin
    wr_cnt <= wr_cnt + 8'h01;
  end
endmodule : rib_ext_dev

// file: tb/rom_io_bus_interface_tb_top.sv
// bench for the rom and external i/o bus interface
module rom_io_bus_interface_tb_top import rib_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
$display("unexpected %s exp %0h got %0h", n, e, g); end end
  localparam logic [25:0] ROM_A = 26'h3A5A5A5;
  localparam logic [25:0] IO1_A = 26'h3000010;
  localparam logic [25:0] IO2_A = 26'h2800020;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic wide_bus_select, cfg_write, rom_write_mode_bit, page_read_mode_bit;
  logic [1:0] bank_alloc_field, bank_alloc_q;
  logic io_bus_width_bit, direction_pin_select, bus_hold;
  logic buffer_use_space_one, buffer_use_space_two;
  logic [2:0] speed_in, rom_mode_q, rom_speed_q, r_rd, r_wr, r_dir;
  logic req_valid, req_write, general_pin_six_out, general_pin_six_oe;
  logic [25:0] req_addr;
  logic [5:0] req_size;
  logic busy_q, size_error_q, io_wide_q, rd_n_q, wr_n_q, r_err, tcpu, r_tc;
  logic shared_pin_out_q, shared_pin_oe_q;
  logic [24:1] addr_pin_q, r_addr;
  logic [7:0] wr_cnt;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [5:0] szs [7] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h10, 6'h20};
  always #2.5 mclk = ~mclk;
  rib_bus_if i_rib_bus_if (.mclk, .sys_rst, .wide_bus_select, .cfg_write,
    .rom_write_mode_bit, .page_read_mode_bit, .bank_alloc_field,
    .io_bus_width_bit, .direction_pin_select, .buffer_use_space_one,
    .buffer_use_space_two, .speed_in, .bus_hold, .req_valid, .req_write,
    .req_addr, .req_size, .general_pin_six_out, .general_pin_six_oe,
    .busy_q, .size_error_q, .rom_mode_q, .bank_alloc_q, .io_wide_q,
    .rom_speed_q, .addr_pin_q, .rd_n_q, .wr_n_q, .shared_pin_out_q,
    .shared_pin_oe_q);
  rib_ext_dev i_rib_ext_dev (.mclk(mclk), .rd_n(rd_n_q), .wr_n(wr_n_q),
    .dir(shared_pin_out_q), .dir_oe(shared_pin_oe_q), .toward_cpu(tcpu),
    .wr_cnt(wr_cnt));
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic cfg(input logic wm, pr, input logic [1:0] bk,
                     input logic iw, input logic [2:0] sp);
    @(negedge mclk);
    rom_write_mode_bit = wm;
    page_read_mode_bit = pr;
    bank_alloc_field = bk;
    io_bus_width_bit = iw;
    speed_in = sp;
    cfg_write = 1'b1;
    @(negedge mclk);
    cfg_write = 1'b0;
    @(negedge mclk);
  endtask : cfg
  task automatic acc(input logic w, input logic [25:0] a,
                     input logic [5:0] s);
    @(negedge mclk);
    req_write = w;
    req_addr = a;
    req_size = s;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    for (int i = 0; i < 3; i++) begin
      r_rd[i] = rd_n_q;
      r_wr[i] = wr_n_q;
      r_dir[i] = shared_pin_out_q;
      if (i == 0) r_addr = addr_pin_q;
      if (i == 0) r_err = size_error_q;
      if (i == 0) r_tc = tcpu;
      @(negedge mclk);
    end
    for (int k = 0; k < 20 && busy_q !== 1'b0; k++) @(negedge mclk);
    @(negedge mclk);
  endtask : acc
  task automatic t_reset();
    `CHK("mode", RIB_ROM_NORMAL, rom_mode_q)
    `CHK("bank", 2'h3, bank_alloc_q)
    `CHK("strobes", 2'h3, {rd_n_q, wr_n_q})
  endtask : t_reset
  task automatic t_addr();
    wide_bus_select = 1'b0;
    acc(1'b0, ROM_A, 6'h04);
    `CHK("addr16", ROM_A[23:1], r_addr[23:1])
    wide_bus_select = 1'b1;
    acc(1'b0, ROM_A, 6'h04);
    `CHK("addr32", {ROM_A[24:2], ROM_A[25]}, r_addr)
  endtask : t_addr
  task automatic t_sizes();
    foreach (szs[j]) begin
      acc(1'b0, ROM_A, szs[j]);
      `CHK("rom size", 2'h0, {r_rd[0], r_err})
      acc(1'b0, IO1_A, szs[j]);
      `CHK("io size", {2{szs[j] == 6'h03}}, {r_rd[0], r_err})
    end
  endtask : t_sizes
  task automatic t_modes();
    wide_bus_select = 1'b0;
    acc(1'b1, ROM_A, 6'h02);
    `CHK("normal wr", 3'h7, r_wr)
    cfg(1'b0, 1'b1, 2'h3, 1'b0, 3'h0);
    `CHK("page", RIB_ROM_PAGE, rom_mode_q)
    acc(1'b1, ROM_A, 6'h02);
    `CHK("page wr", 8'h00, wr_cnt)
    cfg(1'b0, 1'b0, 2'h3, 1'b0, 3'h5);
    `CHK("speed", 3'h5, rom_speed_q)
    cfg(1'b1, 1'b0, 2'h3, 1'b0, 3'h2);
    `CHK("flash", RIB_ROM_FLASH, rom_mode_q)
    `CHK("flash speed", 3'h5, rom_speed_q)
    acc(1'b1, ROM_A, 6'h02);
    `CHK("flash wr", 1'b0, r_wr[0])
    `CHK("flash wr cnt", 8'h01, wr_cnt)
    cfg(1'b0, 1'b0, 2'h3, 1'b0, 3'h0);
    `CHK("normal", RIB_ROM_NORMAL, rom_mode_q)
  endtask : t_modes
  task automatic t_bank();
    cfg(1'b0, 1'b0, 2'h0, 1'b1, 3'h0);
    `CHK("narrow bank", 3'h6, {bank_alloc_q, io_wide_q})
    wide_bus_select = 1'b1;
    cfg(1'b0, 1'b0, 2'h2, 1'b1, 3'h0);
    `CHK("wide bank", 3'h5, {bank_alloc_q, io_wide_q})
    cfg(1'b0, 1'b0, 2'h1, 1'b0, 3'h0);
    `CHK("rfu bank", 3'h4, {bank_alloc_q, io_wide_q})
  endtask : t_bank
  task automatic t_dir();
    direction_pin_select = 1'b1;
    buffer_use_space_two = 1'b1;
    acc(1'b0, IO1_A, 6'h04);
    `CHK("dir io1", 3'h1, r_dir)
    `CHK("toward cpu", 1'b1, r_tc)
    `CHK("dir oe", 1'b1, shared_pin_oe_q)
    acc(1'b0, IO2_A, 6'h04);
    `CHK("dir io2", 3'h0, r_dir)
    buffer_use_space_one = 1'b1;
    buffer_use_space_two = 1'b0;
    acc(1'b0, IO2_A, 6'h04);
    `CHK("dir io2 buf", 3'h1, r_dir)
    acc(1'b1, IO2_A, 6'h04);
    `CHK("dir write", 3'h0, r_dir)
    acc(1'b0, ROM_A, 6'h04);
    `CHK("dir rom", 3'h0, r_dir)
    bus_hold = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK("hold oe", 1'b0, shared_pin_oe_q)
    bus_hold = 1'b0;
    direction_pin_select = 1'b0;
    {general_pin_six_out, general_pin_six_oe} = 2'h3;
    repeat (2) @(negedge mclk);
    `CHK("pin six", 2'h3, {shared_pin_out_q, shared_pin_oe_q})
  endtask : t_dir
  initial begin
    {wide_bus_select, cfg_write, rom_write_mode_bit, page_read_mode_bit} = '0;
    {bank_alloc_field, io_bus_width_bit, direction_pin_select} = '0;
    {buffer_use_space_one, buffer_use_space_two, speed_in, bus_hold} = '0;
    {req_valid, req_write, req_addr, req_size} = '0;
    {general_pin_six_out, general_pin_six_oe} = '0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_addr();
    t_sizes();
    t_modes();
    t_bank();
    t_dir();
    print_verdict();
  end
endmodule : rom_io_bus_interface_tb_top
